// ### hw/itx_pkg.sv
// itx_pkg: constants for the interrupt/timer instruction executor
package itx_pkg;
  // ==========================================================================
  // instruction codes presented by the core
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_IRQ_DISABLE = 5'h01;
  localparam logic [4:0] OP_IRQ_ENABLE = 5'h02;
  localparam logic [4:0] OP_EXT0_TEST = 5'h03;
  localparam logic [4:0] OP_PIN_TEST = 5'h04;
  localparam logic [4:0] OP_RD_ICR1 = 5'h05;
  localparam logic [4:0] OP_WR_ICR1 = 5'h06;
  localparam logic [4:0] OP_RD_ICR2 = 5'h07;
  localparam logic [4:0] OP_WR_ICR2 = 5'h08;
  localparam logic [4:0] OP_RD_ICR3 = 5'h09;
  localparam logic [4:0] OP_WR_ICR3 = 5'h0a;
  localparam logic [4:0] OP_RD_TCR1 = 5'h0b;
  localparam logic [4:0] OP_WR_TCR1 = 5'h0c;
  localparam logic [4:0] OP_RD_TCR2 = 5'h0d;
  localparam logic [4:0] OP_WR_TCR2 = 5'h0e;
  localparam logic [4:0] OP_RD_TCR6 = 5'h0f;
  localparam logic [4:0] OP_WR_TCR6 = 5'h10;
  localparam logic [4:0] OP_T1_READ = 5'h11;
  localparam logic [4:0] OP_T1_WRITE = 5'h12;
  localparam logic [4:0] OP_T2_READ = 5'h13;
  localparam logic [4:0] OP_T2_WRITE = 5'h14;
  localparam logic [4:0] OP_T1_RELOAD_WRITE = 5'h15;
  localparam logic [4:0] OP_T1_TEST = 5'h16;
  localparam logic [4:0] OP_T2_TEST = 5'h17;
  // ==========================================================================
  // field positions
  localparam int EXT0_SKIP_DIS_BIT = 0;
  localparam int T1_SKIP_DIS_BIT = 2;
  localparam int T2_SKIP_DIS_BIT = 3;
  localparam int PIN_POL_BIT = 2;
  // ==========================================================================
  // apb map of the status/control words
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_ICR = 8'h04;
  localparam logic [7:0] ADDR_TCR = 8'h08;
  localparam logic [7:0] ADDR_TIMER = 8'h0c;
  localparam logic [7:0] ADDR_RELOAD = 8'h10;
  localparam logic [7:0] ADDR_SET_FLAGS = 8'h14;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage : itx_pkg

// ### hw/itx_exec.sv
// itx_exec: executes interrupt and timer control instructions
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: disable instruction clears global interrupt enable
// RULE2: enable instruction sets global interrupt enable
// RULE3: ext0 test skips on flag, then clears
// RULE4: ext0 skip-disable is icr1 bit 0, NOP
// RULE5: polarity 0: pin test skips when low
// RULE6: polarity icr3 bit 2; 1 skips high
// RULE7: icr1 read and write via accumulator
// RULE8: icr2 read and write via accumulator
// RULE9: icr3 read and write via accumulator
// RULE10: tcr1 read and write via accumulator
// RULE11: tcr2 read and write via accumulator
// RULE12: tcr6 read and write via accumulator
// RULE13: timer1 read: high to b, low a
// RULE14: timer1 write loads counter and reload
// RULE15: timer2 read: high to b, low a
// RULE16: timer2 write loads counter and reload
// RULE17: reload-only write leaves timer1 counter
// RULE18: timer1 test skips on flag, clears it
// RULE19: timer1 skip-disable is icr1 bit 2
// RULE20: timer2 test skips on flag, clears it
// RULE21: timer2 skip-disable is icr1 bit 3
// RULE22: skipped instruction fetched but has no effect
module itx_exec
  import itx_pkg::*;
#(
  parameter int NIB = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // instruction stream
  input wire logic insn_valid,
  input wire logic [4:0] insn_op,
  input wire logic [NIB-1:0] acc_in,
  input wire logic [NIB-1:0] breg_in,
  input wire logic irq_pin,
  // peripheral events
  input wire logic ext0_event,
  input wire logic timer1_event,
  input wire logic timer2_event,
  // results to the core
  output logic acc_we,
  output logic [NIB-1:0] acc_out,
  output logic breg_we,
  output logic [NIB-1:0] breg_out,
  output logic skip_pending,
  // control outputs to peripherals
  output logic global_irq_enable_flag,
  output logic [2*NIB-1:0] timer1_count,
  output logic [2*NIB-1:0] timer2_count,
  output logic [2*NIB-1:0] timer1_reload_reg,
  output logic [2*NIB-1:0] timer2_reload_reg,
  output logic timer1_load,
  output logic timer2_load,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ==========================================================================
  // state
  logic gie_q;
  logic ext0_request_flag;
  logic timer1_request_flag;
  logic timer2_request_flag;
  logic [NIB-1:0] irq_control_reg_first;
  logic [NIB-1:0] irq_control_reg_second;
  logic [NIB-1:0] irq_control_reg_third;
  logic [NIB-1:0] timer_control_reg_first;
  logic [NIB-1:0] timer_control_reg_second;
  logic [NIB-1:0] timer_control_reg_sixth;
  logic [2*NIB-1:0] t1_cnt_q;
  logic [2*NIB-1:0] t2_cnt_q;
  logic [2*NIB-1:0] r1_q;
  logic [2*NIB-1:0] r2_q;
  logic skip_q;
  logic [7:0] set_flags;
  logic apb_wr;
  logic apb_rd;
  logic exec;
  logic ext0_skip_disable_bit;
  logic timer1_skip_disable_bit;
  logic timer2_skip_disable_bit;
  logic irq_pin_polarity_bit;
  logic ext0_hit;
  logic t1_hit;
  logic t2_hit;
  logic pin_hit;
  logic skip_d;

  assign ext0_skip_disable_bit = irq_control_reg_first[EXT0_SKIP_DIS_BIT];
  assign timer1_skip_disable_bit = irq_control_reg_first[T1_SKIP_DIS_BIT];
  assign timer2_skip_disable_bit = irq_control_reg_first[T2_SKIP_DIS_BIT];
  assign irq_pin_polarity_bit = irq_control_reg_third[PIN_POL_BIT];

  // a skipped slot still arrives but is swallowed here
  assign exec = insn_valid && !skip_q; // see RULE22

  // ==========================================================================
  // skip decisions
  assign ext0_hit = exec && insn_op == OP_EXT0_TEST &&
    !ext0_skip_disable_bit && ext0_request_flag; // see RULE3 see RULE4
  assign t1_hit = exec && insn_op == OP_T1_TEST &&
    !timer1_skip_disable_bit && timer1_request_flag; // see RULE18 see RULE19
  assign t2_hit = exec && insn_op == OP_T2_TEST &&
    !timer2_skip_disable_bit && timer2_request_flag; // see RULE20 see RULE21
  assign pin_hit = exec && insn_op == OP_PIN_TEST &&
    (irq_pin == irq_pin_polarity_bit); // see RULE5 see RULE6
  assign skip_d = ext0_hit || t1_hit || t2_hit || pin_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= 1'b0;
    end else if (insn_valid) begin
      skip_q <= skip_d; // see RULE22
    end
  end
  assign skip_pending = skip_q;

  // ==========================================================================
  // global enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_q <= 1'b0;
    end else if (exec && insn_op == OP_IRQ_DISABLE) begin
      gie_q <= 1'b0; // see RULE1
    end else if (exec && insn_op == OP_IRQ_ENABLE) begin
      gie_q <= 1'b1; // see RULE2
    end
  end
  assign global_irq_enable_flag = gie_q;

  // ==========================================================================
  // request flags: a new event wins over the skip clear
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign set_flags = (apb_wr && paddr == ADDR_SET_FLAGS) ?
    pwdata[7:0] : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext0_request_flag <= 1'b0;
    end else if (ext0_event || set_flags[0]) begin
      ext0_request_flag <= 1'b1;
    end else if (ext0_hit) begin
      ext0_request_flag <= 1'b0; // see RULE3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_request_flag <= 1'b0;
    end else if (timer1_event || set_flags[1]) begin
      timer1_request_flag <= 1'b1;
    end else if (t1_hit) begin
      timer1_request_flag <= 1'b0; // see RULE18
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer2_request_flag <= 1'b0;
    end else if (timer2_event || set_flags[2]) begin
      timer2_request_flag <= 1'b1;
    end else if (t2_hit) begin
      timer2_request_flag <= 1'b0; // see RULE20
    end
  end

  // ==========================================================================
  // control nibbles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_control_reg_first <= NIB_RESET;
      irq_control_reg_second <= NIB_RESET;
      irq_control_reg_third <= NIB_RESET;
      timer_control_reg_first <= NIB_RESET;
      timer_control_reg_second <= NIB_RESET;
      timer_control_reg_sixth <= NIB_RESET;
    end else if (exec) begin
      case (insn_op)
        OP_WR_ICR1: irq_control_reg_first <= acc_in; // see RULE7
        OP_WR_ICR2: irq_control_reg_second <= acc_in; // see RULE8
        OP_WR_ICR3: irq_control_reg_third <= acc_in; // see RULE9
        OP_WR_TCR1: timer_control_reg_first <= acc_in; // see RULE10
        OP_WR_TCR2: timer_control_reg_second <= acc_in; // see RULE11
        OP_WR_TCR6: timer_control_reg_sixth <= acc_in; // see RULE12
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // timers: counting lives in the peripheral; these mirror its loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_cnt_q <= BYTE_RESET;
      r1_q <= BYTE_RESET;
    end else if (exec && insn_op == OP_T1_WRITE) begin
      t1_cnt_q <= {breg_in, acc_in}; // see RULE14
      r1_q <= {breg_in, acc_in}; // see RULE14
    end else if (exec && insn_op == OP_T1_RELOAD_WRITE) begin
      r1_q <= {breg_in, acc_in}; // see RULE17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_cnt_q <= BYTE_RESET;
      r2_q <= BYTE_RESET;
    end else if (exec && insn_op == OP_T2_WRITE) begin
      t2_cnt_q <= {breg_in, acc_in}; // see RULE16
      r2_q <= {breg_in, acc_in}; // see RULE16
    end
  end

  assign timer1_count = t1_cnt_q;
  assign timer2_count = t2_cnt_q;
  assign timer1_reload_reg = r1_q;
  assign timer2_reload_reg = r2_q;
  assign timer1_load = exec && insn_op == OP_T1_WRITE;
  assign timer2_load = exec && insn_op == OP_T2_WRITE;

  // ==========================================================================
  // accumulator and b results, combinational in the execute cycle
  always_comb begin
    acc_we = exec;
    breg_we = 1'b0;
    acc_out = NIB_RESET;
    breg_out = NIB_RESET;
    case (insn_op)
      OP_RD_ICR1: acc_out = irq_control_reg_first; // see RULE7
      OP_RD_ICR2: acc_out = irq_control_reg_second; // see RULE8
      OP_RD_ICR3: acc_out = irq_control_reg_third; // see RULE9
      OP_RD_TCR1: acc_out = timer_control_reg_first; // see RULE10
      OP_RD_TCR2: acc_out = timer_control_reg_second; // see RULE11
      OP_RD_TCR6: acc_out = timer_control_reg_sixth; // see RULE12
      OP_T1_READ: begin
        acc_out = t1_cnt_q[NIB-1:0]; // see RULE13
        breg_out = t1_cnt_q[2*NIB-1:NIB];
        breg_we = exec;
      end
      OP_T2_READ: begin
        acc_out = t2_cnt_q[NIB-1:0]; // see RULE15
        breg_out = t2_cnt_q[2*NIB-1:NIB];
        breg_we = exec;
      end
      default: acc_we = 1'b0;
    endcase
  end

  // ==========================================================================
  // apb: zero wait states, unmapped reads zero with pslverr
  assign pready = 1'b1;
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == ADDR_STATUS) begin
      prdata[4:0] = {skip_q, timer2_request_flag, timer1_request_flag,
                     ext0_request_flag, gie_q};
    end else if (paddr == ADDR_ICR) begin
      prdata[11:0] = {irq_control_reg_third, irq_control_reg_second,
                      irq_control_reg_first};
    end else if (paddr == ADDR_TCR) begin
      prdata[11:0] = {timer_control_reg_sixth, timer_control_reg_second,
                      timer_control_reg_first};
    end else if (paddr == ADDR_TIMER) begin
      prdata[15:0] = {t2_cnt_q, t1_cnt_q};
    end else if (paddr == ADDR_RELOAD) begin
      prdata[15:0] = {r2_q, r1_q};
    end else if (paddr != ADDR_SET_FLAGS) begin
      pslverr = psel && penable;
    end
    if (!apb_rd) begin
      prdata = 32'h0000_0000;
    end
  end

  // ==========================================================================
  // checks
  gie_off_a: assert property ( // see RULE1
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_IRQ_DISABLE |=> !global_irq_enable_flag)
    else $error("enable flag not cleared");
  gie_on_a: assert property ( // see RULE2
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_IRQ_ENABLE |=> global_irq_enable_flag)
    else $error("enable flag not set");
  ext0_skip_a: assert property ( // see RULE3
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_EXT0_TEST && !ext0_skip_disable_bit &&
    ext0_request_flag && !ext0_event && !set_flags[0]
    |=> skip_pending && !ext0_request_flag)
    else $error("ext0 test did not skip and clear");
  // a fresh event may still raise the flag during a disabled test
  ext0_nop_a: assert property ( // see RULE4
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_EXT0_TEST && ext0_skip_disable_bit
    |=> !skip_pending && (!$past(ext0_request_flag) || ext0_request_flag))
    else $error("disabled ext0 test acted");
  pin_skip_a: assert property ( // see RULE5 see RULE6
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_PIN_TEST |=> skip_pending ==
    ($past(irq_pin_polarity_bit) ? $past(irq_pin) : !$past(irq_pin)))
    else $error("pin test skip wrong");
  t1_write_a: assert property ( // see RULE14
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_T1_WRITE |=> timer1_count == timer1_reload_reg &&
    timer1_count == {$past(breg_in), $past(acc_in)})
    else $error("timer1 write wrong");
  t2_write_a: assert property ( // see RULE16
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_T2_WRITE |=> timer2_count == timer2_reload_reg &&
    timer2_count == {$past(breg_in), $past(acc_in)})
    else $error("timer2 write wrong");
  reload_only_a: assert property ( // see RULE17
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_T1_RELOAD_WRITE |=> $stable(timer1_count) &&
    timer1_reload_reg == {$past(breg_in), $past(acc_in)})
    else $error("reload-only write wrong");
  t1_skip_a: assert property ( // see RULE18
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_T1_TEST && !timer1_skip_disable_bit &&
    timer1_request_flag && !timer1_event && !set_flags[1]
    |=> skip_pending && !timer1_request_flag)
    else $error("timer1 test did not skip and clear");
  t1_nop_a: assert property ( // see RULE19
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_T1_TEST && timer1_skip_disable_bit
    |=> !skip_pending && (!$past(timer1_request_flag) || timer1_request_flag))
    else $error("disabled timer1 test acted");
  t2_skip_a: assert property ( // see RULE20
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_T2_TEST && !timer2_skip_disable_bit &&
    timer2_request_flag && !timer2_event && !set_flags[2]
    |=> skip_pending && !timer2_request_flag)
    else $error("timer2 test did not skip and clear");
  t2_nop_a: assert property ( // see RULE21
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_T2_TEST && timer2_skip_disable_bit
    |=> !skip_pending && (!$past(timer2_request_flag) || timer2_request_flag))
    else $error("disabled timer2 test acted");
  skipped_quiet_a: assert property ( // see RULE22
    @(posedge pclk) disable iff (!presetn)
    skip_pending && insn_valid |-> !acc_we && !breg_we &&
    !timer1_load && !timer2_load)
    else $error("skipped instruction had effect");
  t1_read_a: assert property ( // see RULE13
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_T1_READ |-> acc_we && breg_we &&
    {breg_out, acc_out} == timer1_count)
    else $error("timer1 read wrong");
  t2_read_a: assert property ( // see RULE15
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_T2_READ |-> acc_we && breg_we &&
    {breg_out, acc_out} == timer2_count)
    else $error("timer2 read wrong");
  icr1_read_a: assert property ( // see RULE7
    @(posedge pclk) disable iff (!presetn)
    exec && insn_op == OP_RD_ICR1 |-> acc_we &&
    acc_out == irq_control_reg_first)
    else $error("icr1 read wrong");

  ext0_skip_c: cover property (@(posedge pclk) ext0_hit);
  t2_skip_c: cover property (@(posedge pclk) t2_hit);
  t1_skip_c: cover property (@(posedge pclk) t1_hit);
  pin_skip_c: cover property (@(posedge pclk) pin_hit);
  skip_swallow_c: cover property (@(posedge pclk)
    skip_pending && insn_valid && insn_op == OP_T1_WRITE);
endmodule : itx_exec

// ### verif/itx_periph_model.sv
// itx_periph_model: event sources and interrupt pin beside the executor
`timescale 1ns/100ps
module itx_periph_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the bench
  input wire logic [2:0] ev_req,
  input wire logic pin_lvl,
  // towards the executor
  output logic ext0_event,
  output logic timer1_event,
  output logic timer2_event,
  output logic irq_pin
);
  // ==========================================================================
  // request pulses
  // one-cycle pulses, as an underflow or an edge detector would give
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {timer2_event, timer1_event, ext0_event} <= 3'h0;
    end else begin
      {timer2_event, timer1_event, ext0_event} <= ev_req;
    end
  end
  // ==========================================================================
  // interrupt pin
  // synchronised here so the executor never sees a mid-cycle change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pin <= 1'b1;
    end else begin
      irq_pin <= pin_lvl;
    end
  end
endmodule : itx_periph_model

// ### verif/tb_top.sv
// tb_top: self-checking bench for the instruction executor
`timescale 1ns/100ps
module tb_top;
  import itx_pkg::*;
  // ==========================================================================
  // signals
  logic pclk, presetn, insn_valid, psel, penable, pwrite, pready, pslverr;
  logic [4:0] insn_op;
  logic [3:0] acc_in, breg_in, acc_out, breg_out, c_acc, c_breg;
  logic [7:0] paddr, t1c, t2c, t1r, t2r;
  logic [31:0] pwdata, prdata, rd;
  logic acc_we, breg_we, skip_pending, gie, ld1, ld2, err;
  logic irq_pin, ev0, ev1, ev2, pin_lvl, c_awe, c_bwe, c_ld1, c_ld2;
  logic [2:0] ev_req;
  int num_errors, checks_done;
  logic [4:0] wop[6] = '{OP_WR_ICR1, OP_WR_ICR2, OP_WR_ICR3, OP_WR_TCR1,
    OP_WR_TCR2, OP_WR_TCR6};
  logic [4:0] rop[6] = '{OP_RD_ICR1, OP_RD_ICR2, OP_RD_ICR3, OP_RD_TCR1,
    OP_RD_TCR2, OP_RD_TCR6};
  logic [4:0] top[3] = '{OP_EXT0_TEST, OP_T1_TEST, OP_T2_TEST};
  int dbit[3] = '{EXT0_SKIP_DIS_BIT, T1_SKIP_DIS_BIT, T2_SKIP_DIS_BIT};
  // ==========================================================================
  // instances
  itx_exec i_itx_exec (.pclk(pclk), .presetn(presetn),
    .insn_valid(insn_valid), .insn_op(insn_op), .acc_in(acc_in),
    .breg_in(breg_in), .irq_pin(irq_pin), .ext0_event(ev0),
    .timer1_event(ev1), .timer2_event(ev2), .acc_we(acc_we),
    .acc_out(acc_out), .breg_we(breg_we), .breg_out(breg_out),
    .skip_pending(skip_pending), .global_irq_enable_flag(gie),
    .timer1_count(t1c), .timer2_count(t2c), .timer1_reload_reg(t1r),
    .timer2_reload_reg(t2r), .timer1_load(ld1), .timer2_load(ld2),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  itx_periph_model i_itx_periph_model (.pclk(pclk), .presetn(presetn),
    .ev_req(ev_req), .pin_lvl(pin_lvl), .ext0_event(ev0),
    .timer1_event(ev1), .timer2_event(ev2), .irq_pin(irq_pin));
  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // comb answers are captured 1ns after the driving edge, effects read after the next edge
  task automatic ins(input logic [4:0] op, input logic [3:0] a, b);
    @(posedge pclk);
    insn_valid <= 1'b1;
    insn_op <= op;
    acc_in <= a;
    breg_in <= b;
    #1;
    {c_awe, c_acc, c_bwe, c_breg} = {acc_we, acc_out, breg_we, breg_out};
    {c_ld1, c_ld2} = {ld1, ld2};
    @(posedge pclk);
    insn_valid <= 1'b0;
    #1;
  endtask : ins
  // waits for pready without limit; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic close_out();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // ==========================================================================
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // the sequence needs well under a thousand cycles
  initial begin
    #(40 * 4000);
    num_errors++;
    close_out();
  end
  // ==========================================================================
  // tests
  initial begin
    {insn_valid, psel, penable, pwrite, pin_lvl} = 5'h00;
    {insn_op, acc_in, breg_in, paddr, pwdata, ev_req} = '0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, ADDR_TIMER, 32'hff);
    apb(1'b0, ADDR_TIMER, 32'h0);
    chk(rd, 32'h0);
    ins(OP_IRQ_ENABLE, 4'h0, 4'h0);
    chk(32'(gie), 32'h1);
    ins(OP_IRQ_DISABLE, 4'h0, 4'h0);
    chk(32'(gie), 32'h0);
    for (int i = 0; i < 6; i++) begin
      ins(wop[i], 4'(i + 5), 4'h0);
      ins(rop[i], 4'h0, 4'h0);
      if (i < 3) chk(32'({c_awe, c_acc}), 32'h15 + i);
      else chk(32'({c_awe, c_acc}), 32'h15 + i);
    end
    apb(1'b0, ADDR_ICR, 32'h0);
    chk(rd, 32'h765);
    apb(1'b0, ADDR_TCR, 32'h0);
    chk(rd, 32'ha98);
    ins(OP_WR_ICR1, 4'h0, 4'h0);
    ins(OP_WR_ICR3, 4'h0, 4'h0);
    ins(OP_T1_WRITE, 4'hc, 4'h3);
    chk(32'({c_ld1, t1c, t1r}), 32'h13c3c);
    ins(OP_T1_RELOAD_WRITE, 4'h5, 4'ha);
    chk(32'({t1c, t1r}), 32'h3ca5);
    ins(OP_T1_READ, 4'h0, 4'h0);
    chk(32'({4'(c_bwe), c_breg, 4'(c_awe), c_acc}), 32'h131c);
    ins(OP_T2_WRITE, 4'h1, 4'he);
    chk(32'({c_ld2, t2c, t2r}), 32'h1e1e1);
    ins(OP_T2_READ, 4'h0, 4'h0);
    chk(32'({4'(c_bwe), c_breg, 4'(c_awe), c_acc}), 32'h1e11);
    apb(1'b0, ADDR_RELOAD, 32'h0);
    chk(rd, 32'he1a5);
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      ev_req <= 3'(1 << k);
      @(posedge pclk);
      ev_req <= 3'h0;
      repeat (2) @(posedge pclk);
      ins(OP_WR_ICR1, 4'(1 << dbit[k]), 4'h0);
      ins(top[k], 4'h0, 4'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'(2 << k));
      ins(OP_WR_ICR1, 4'h0, 4'h0);
      ins(top[k], 4'h0, 4'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h10);
      ins(OP_IRQ_ENABLE, 4'h0, 4'h0);
      chk(32'({skip_pending, gie}), 32'h0);
      ins(top[k], 4'h0, 4'h0);
      chk(32'(skip_pending), 32'h0);
    end
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < 2; l++) begin
        @(posedge pclk);
        pin_lvl <= 1'(l);
        ins(OP_WR_ICR3, 4'(p << PIN_POL_BIT), 4'h0);
        ins(OP_PIN_TEST, 4'h0, 4'h0);
        chk(32'(skip_pending), 32'(p == l));
        ins(OP_NOP, 4'h0, 4'h0);
      end
    end
    // software flag set, then a skip that swallows a timer write
    apb(1'b1, ADDR_SET_FLAGS, 32'h7);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'he);
    ins(OP_T1_TEST, 4'h0, 4'h0);
    ins(OP_T1_WRITE, 4'hf, 4'hf);
    chk(32'({c_ld1, t1c, t1r}), 32'h03ca5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'ha);
    close_out();
  end
endmodule : tb_top
